// >>> verilog/pcrr_pkg.sv
/*
 * Constants, types and decode helpers for the clock generation and
 * reset-release block. Assumes one clock that stands for the VCO output.
 */
// Notes on behaviour
// - VCO runs at twice multiplier times input.
// - Core clock is VCO over 2, 4, 8, 16.
// - Reset forces the post-divider to two.
// - Input halving divides reference clock by two.
// - Straps load multiplier during reset; software later.
// - Peripheral clock period is two core periods.
// - Core reset holds 4096 reference plus two core.
// - A missed setup may add one reference cycle.
package pcrr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PCRR_PWR_CTRL_OFS = 12'h000;
    localparam logic [11:0] PCRR_STATUS_OFS = 12'h004;

    localparam int PCRR_MULT_LSB = 0;
    localparam int PCRR_MULT_W = 7;
    localparam int PCRR_DIV_LSB = 8;
    localparam int PCRR_HALVE_BIT = 10;
    localparam int PCRR_SDR_LSB = 12;
    localparam int PCRR_SDR_W = 4;

    localparam int PCRR_ST_RESET_BIT = 0;
    localparam int PCRR_ST_EXT_BIT = 1;
    localparam int PCRR_ST_STATE_LSB = 2;
    localparam int PCRR_ST_CNT_LSB = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] PCRR_MULT_RST = 7'h10;
    localparam logic [1:0] PCRR_DIV_RST = 2'h0;
    localparam logic PCRR_HALVE_RST = 1'b0;
    localparam logic [3:0] PCRR_SDR_RST = 4'h2;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam int PCRR_REF_HOLD_CYCLES = 4096;
    localparam int PCRR_CORE_HOLD_CYCLES = 2;
    localparam int PCRR_PERIPH_RATIO = 2;

    localparam logic [1:0] PCRR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCRR_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PCRR_ST_EXT = 2'b00,
        PCRR_ST_REF = 2'b01,
        PCRR_ST_CORE = 2'b10,
        PCRR_ST_RUN = 2'b11
    } pcrr_state_t;

    // Strap code to multiplier; the board picks one of four ratios.
    function automatic logic [6:0] pcrr_strap_mult(input logic [1:0] code);
        logic [6:0] m;
        m = 7'h08;
        unique case (code)
            2'h0: m = 7'h08;
            2'h1: m = 7'h10;
            2'h2: m = 7'h20;
            2'h3: m = 7'h18;
        endcase
        return m;
    endfunction

    // Post-divider select to divide value: 2, 4, 8 or 16.
    function automatic logic [4:0] pcrr_div_value(input logic [1:0] sel);
        return 5'h02 << sel;
    endfunction

endpackage

// >>> verilog/pcrr_tick_div.sv
/*
 * Tick divider: counts input ticks and emits one output tick every div
 * input ticks and a clock of that period, square for even div; at a div
 * of one the clock toggles every cycle. Assumes div is steady within a
 * period; a divisor of zero acts as one.
 */
`timescale 1ns/1ns
module pcrr_tick_div
    import pcrr_pkg::*;
#(
    parameter int W = 9
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick_in,
    input wire logic [W-1:0] div,
    output logic tick_out,
    output logic clk_out
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_q;
    logic clk_q;
    wire [W-1:0] div_eff = (div == '0) ? W'(1) : div;
    // A shrinking divisor must not strand the count above the new end.
    wire wrap = tick_in && (cnt_q >= div_eff - W'(1));
    wire [W-1:0] half = div_eff >> 1;

    assign cnt_d = wrap ? '0 : (tick_in ? cnt_q + W'(1) : cnt_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= wrap;
            clk_q <= (div_eff == W'(1)) ? ~clk_q : (cnt_d < half);
        end
    end

    assign tick_out = tick_q;
    assign clk_out = clk_q;

endmodule

// >>> verilog/pcrr_top.sv
/*
 * Clock generation and core reset release with an AXI4-Lite register
 * slave. The clock aclk stands for the VCO output; the core, peripheral
 * and SDRAM clocks are derived from it as ticks and square waves (SDRAM only at even ratios or one), the
 * reference as a tick only. Assumes the external reset input and straps are
 * synchronous to aclk.
 */
`timescale 1ns/1ns
module pcrr_top
    import pcrr_pkg::*;
#(
    parameter int AW = 12,
    parameter int REF_HOLD = PCRR_REF_HOLD_CYCLES,
    parameter int CNT_W = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n,
    input wire logic [1:0] clock_ratio_straps,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_reset_n,
    output logic ref_tick,
    output logic core_clk,
    output logic core_tick,
    output logic periph_clk,
    output logic periph_tick,
    output logic sdram_clk,
    output logic sdram_tick,
    output logic [6:0] clock_multiplier,
    output logic [4:0] core_post_divider,
    output logic input_halving_enable
);

    // ------------------------------------------------------------------
    // External reset stage
    // ------------------------------------------------------------------
    logic ext_q;
    wire ext_active = !ext_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_reset_n;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    logic aw_q;
    logic w_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire aw_take = s_axi_awvalid && !aw_q;
    wire w_take = s_axi_wvalid && !w_q;
    wire wr_fire = aw_q && w_q && !bvalid_q;
    wire wr_ctrl = (awaddr_q[AW-1:2] == PCRR_PWR_CTRL_OFS[AW-1:2]);
    wire wr_stat = (awaddr_q[AW-1:2] == PCRR_STATUS_OFS[AW-1:2]);
    wire ctrl_we = wr_fire && wr_ctrl;

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            awaddr_q <= '0;
        end else if (aw_take) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (w_take) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= PCRR_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_ctrl || wr_stat) ? PCRR_RESP_OKAY : PCRR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Power management control register
    // ------------------------------------------------------------------
    logic [6:0] mult_q;
    logic [1:0] div_q;
    logic halve_q;
    logic [3:0] sdr_q;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_mask;
    logic [31:0] ctrl_new;

    assign ctrl_word = {16'h0000, sdr_q, 1'b0, halve_q, div_q, 1'b0, mult_q};
    assign ctrl_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign ctrl_new = (ctrl_word & ~ctrl_mask) | (wdata_q & ctrl_mask);

    // The external reset wins over a write landing in the same cycle, so
    // the core leaves reset with the strapped ratio and divide by 2 unless a write lands after the external reset ends.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mult_q <= PCRR_MULT_RST;
            div_q <= PCRR_DIV_RST;
            halve_q <= PCRR_HALVE_RST;
            sdr_q <= PCRR_SDR_RST;
        end else if (ext_active) begin
            mult_q <= pcrr_strap_mult(clock_ratio_straps);
            div_q <= PCRR_DIV_RST;
            halve_q <= PCRR_HALVE_RST;
            sdr_q <= PCRR_SDR_RST;
        end else if (ctrl_we) begin
            mult_q <= ctrl_new[PCRR_MULT_LSB +: PCRR_MULT_W];
            div_q <= ctrl_new[PCRR_DIV_LSB +: 2];
            halve_q <= ctrl_new[PCRR_HALVE_BIT];
            sdr_q <= ctrl_new[PCRR_SDR_LSB +: PCRR_SDR_W];
        end
    end

    assign clock_multiplier = mult_q;
    assign core_post_divider = pcrr_div_value(div_q);
    assign input_halving_enable = halve_q;

    // ------------------------------------------------------------------
    // Clock derivation
    // ------------------------------------------------------------------
    // One reference period spans 2 x multiplier VCO periods, doubled when
    // the input is halved. Range limits on the product are software's job.
    wire [6:0] mult_eff = (mult_q == 7'h00) ? 7'h01 : mult_q;
    wire [8:0] ref_div = {1'b0, mult_eff, 1'b0} << halve_q;
    wire [4:0] core_div = pcrr_div_value(div_q);
    wire [3:0] sdr_div = sdr_q;

    pcrr_tick_div #(.W(9)) u_ref_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(1'b1),
        .div(ref_div),
        .tick_out(ref_tick),
        .clk_out()
    );

    pcrr_tick_div #(.W(5)) u_core_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(1'b1),
        .div(core_div),
        .tick_out(core_tick),
        .clk_out(core_clk)
    );

    pcrr_tick_div #(.W(2)) u_periph_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(core_tick),
        .div(2'(PCRR_PERIPH_RATIO)),
        .tick_out(periph_tick),
        .clk_out(periph_clk)
    );

    pcrr_tick_div #(.W(4)) u_sdram_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(core_tick),
        .div(sdr_div),
        .tick_out(sdram_tick),
        .clk_out(sdram_clk)
    );

    // ------------------------------------------------------------------
    // Core reset release
    // ------------------------------------------------------------------
    pcrr_state_t st_q;
    pcrr_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic core_rst_n_q;

    wire ref_last = (cnt_q == CNT_W'(REF_HOLD));
    wire core_last = (cnt_q == CNT_W'(PCRR_CORE_HOLD_CYCLES));

    // The dividers run free, so the first tick seen in a count state only
    // marks a period boundary. Counting one tick past the hold keeps whole
    // periods, at the cost of up to one extra period of reset.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (ext_active) begin
            st_d = PCRR_ST_EXT;
            cnt_d = '0;
        end else begin
            unique case (st_q)
                PCRR_ST_EXT: begin
                    st_d = PCRR_ST_REF;
                    cnt_d = '0;
                end
                PCRR_ST_REF: begin
                    if (ref_tick) begin
                        cnt_d = ref_last ? '0 : cnt_q + CNT_W'(1);
                        if (ref_last) begin
                            st_d = PCRR_ST_CORE;
                        end
                    end
                end
                PCRR_ST_CORE: begin
                    if (core_tick) begin
                        cnt_d = core_last ? '0 : cnt_q + CNT_W'(1);
                        if (core_last) begin
                            st_d = PCRR_ST_RUN;
                        end
                    end
                end
                PCRR_ST_RUN: begin
                    cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= PCRR_ST_EXT;
            cnt_q <= '0;
            core_rst_n_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            core_rst_n_q <= (st_d == PCRR_ST_RUN);
        end
    end

    assign core_reset_n = core_rst_n_q;

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] status_word;

    wire ar_take = s_axi_arvalid && !rvalid_q;
    wire rd_ctrl = (s_axi_araddr[AW-1:2] == PCRR_PWR_CTRL_OFS[AW-1:2]);
    wire rd_stat = (s_axi_araddr[AW-1:2] == PCRR_STATUS_OFS[AW-1:2]);

    always_comb begin
        status_word = '0;
        status_word[PCRR_ST_RESET_BIT] = !core_rst_n_q;
        status_word[PCRR_ST_EXT_BIT] = ext_active;
        status_word[PCRR_ST_STATE_LSB +: 2] = st_q;
        status_word[PCRR_ST_CNT_LSB +: CNT_W] = cnt_q;
    end

    wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? status_word : 32'h0000_0000);

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= PCRR_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_ctrl || rd_stat) ? PCRR_RESP_OKAY : PCRR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// >>> sim/pcrr_monitor.sv
/* Checker on the clock block top ports. Assumes one clock and aresetn sync low. */
`timescale 1ns/1ns
module pcrr_monitor
    import pcrr_pkg::*;
#(
    parameter int REF_HOLD = 4096
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n,
    input wire logic [1:0] clock_ratio_straps,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic core_reset_n,
    input wire logic ref_tick,
    input wire logic core_tick,
    input wire logic periph_tick,
    input wire logic [6:0] clock_multiplier,
    input wire logic [4:0] core_post_divider,
    input wire logic input_halving_enable
);
    // ----
    // Period helpers
    // ----
    logic [6:0] strap_tab [4] = '{7'h08, 7'h10, 7'h20, 7'h18};
    logic [4:0] cgap_q, cdiv_q;
    logic [9:0] rgap_q, rexp_q;
    logic [2:0] pcnt_q;
    logic [15:0] rcnt_q;
    logic cseen_q, rseen_q, pseen_q;
    wire [9:0] rexp = input_halving_enable ? {1'b0, clock_multiplier, 2'b0} :
        {2'b0, clock_multiplier, 1'b0};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {cgap_q, cdiv_q, rgap_q, rexp_q, pcnt_q, rcnt_q} <= '0;
            {cseen_q, rseen_q, pseen_q} <= 3'h0;
        end else begin
            cseen_q <= cseen_q | core_tick;
            rseen_q <= rseen_q | ref_tick;
            pseen_q <= pseen_q | periph_tick;
            cgap_q <= core_tick ? 5'h01 : cgap_q + {4'h0, cgap_q != 5'h1f};
            cdiv_q <= core_tick ? core_post_divider : cdiv_q;
            rgap_q <= ref_tick ? 10'h001 : rgap_q + {9'h0, rgap_q != 10'h3ff};
            rexp_q <= ref_tick ? rexp : rexp_q;
            pcnt_q <= periph_tick ? 3'h0 : pcnt_q + {2'h0, core_tick};
            rcnt_q <= ext_reset_n ? rcnt_q + {15'h0, ref_tick} : 16'h0;
        end
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Four cycles leave room for the input flop ahead of the forced values.
    sequence s_ext_held;
        !ext_reset_n [*4];
    endsequence
    a_div_forced: assert property (s_ext_held |-> core_post_divider == 5'h02)
        else $error("divider not two during board reset");
    a_strap_load: assert property (s_ext_held |-> clock_multiplier == strap_tab[$past(clock_ratio_straps)])
        else $error("multiplier does not follow straps");
    a_core_held: assert property (s_ext_held |-> !core_reset_n)
        else $error("core left reset during board reset");
    a_core_period: assert property (core_tick && cseen_q && cdiv_q == core_post_divider |-> cgap_q == core_post_divider)
        else $error("core period differs from divider");
    a_ref_period: assert property (ref_tick && rseen_q && rexp_q == rexp && rexp != 10'h0 |-> rgap_q == rexp)
        else $error("reference period wrong");
    a_periph_period: assert property (periph_tick && pseen_q |-> pcnt_q + {2'h0, core_tick} == 3'h2)
        else $error("peripheral period not two core periods");
    a_release_hold: assert property ($rose(core_reset_n) |-> rcnt_q >= REF_HOLD)
        else $error("core released too early");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule
bind pcrr_top pcrr_monitor #(.REF_HOLD(REF_HOLD)) pcrr_monitor_inst (.aclk, .aresetn, .ext_reset_n,
    .clock_ratio_straps, .s_axi_bready, .s_axi_bresp, .s_axi_bvalid, .core_reset_n, .ref_tick,
    .core_tick, .periph_tick, .clock_multiplier, .core_post_divider, .input_halving_enable);

// >>> sim/pcrr_board_model.sv
/* Board reset source and strap pins. Assumes aclk paces the reference. */
`timescale 1ns/1ns
module pcrr_board_model #(
    parameter int LOW = 2000
) (
    input wire logic aclk,
    input wire logic go,
    input wire logic [1:0] code,
    output logic ext_reset_n,
    output logic [1:0] clock_ratio_straps
);
    // At 10 ns a cycle the default low time is 20 us, enough for both the
    // stable clock and the strap setup time ahead of every release.
    logic [15:0] hold_q = 16'(LOW);
    logic rst_n_q = 1'b0;
    logic [1:0] strap_q = 2'h2;
    assign ext_reset_n = rst_n_q;
    assign clock_ratio_straps = strap_q;
    // Straps change only at the start, so they are set up for the whole low time.
    always @(posedge aclk) begin
        if (go) begin
            hold_q <= 16'(LOW);
            rst_n_q <= 1'b0;
            strap_q <= code;
        end else if (hold_q != 16'h0) begin
            hold_q <= hold_q - 16'h1;
        end else begin
            rst_n_q <= 1'b1;
        end
    end
endmodule

// >>> sim/testbench.sv
/* Self-checking bench for the clock block. Assumes the board model and AXI4-Lite tasks. */
`timescale 1ns/1ns
module testbench;
    import pcrr_pkg::*;
    localparam int REF_HOLD = 8;
    int n_mismatch = 0;
    int checks = 0;
    int mt [4] = '{8, 16, 32, 24};
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    logic [1:0] code = 2'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic ext_reset_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic core_reset_n, ref_tick, core_clk, core_tick, periph_clk, periph_tick;
    logic sdram_clk, sdram_tick, input_halving_enable;
    logic [1:0] clock_ratio_straps, s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [6:0] clock_multiplier;
    logic [4:0] core_post_divider;
    wire [3:0] ticks = {sdram_tick, periph_tick, core_tick, ref_tick};
    wire [3:0] clks = {sdram_clk, periph_clk, core_clk, 1'b0};
    initial begin
        forever #5 aclk = ~aclk;
    end
    pcrr_top #(.REF_HOLD(REF_HOLD)) pcrr_top_inst (.aclk, .aresetn, .ext_reset_n,
        .clock_ratio_straps, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .core_reset_n, .ref_tick, .core_clk, .core_tick, .periph_clk,
        .periph_tick, .sdram_clk, .sdram_tick, .clock_multiplier, .core_post_divider,
        .input_halving_enable);
    pcrr_board_model pcrr_board_model_inst (.aclk, .go, .code, .ext_reset_n,
        .clock_ratio_straps);
    task automatic conclude;
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        chk(32'h0, 32'h1);
        conclude;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k == 50) tmo;
    endtask
    task automatic rd(input logic [11:0] a);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {r, d} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
        if (k == 50) tmo;
    endtask
    task automatic wtick(input int s);
        int k;
        for (k = 0; k < 600; k++) begin
            @(negedge aclk);
            if (ticks[s]) break;
        end
        if (k == 600) tmo;
    endtask
    // The first period after a change may be cut short, so it is skipped.
    task automatic period(input int s, input int e, input int hi);
        int n;
        int h;
        wtick(s);
        wtick(s);
        h = 0;
        for (n = 1; n < 600; n++) begin
            @(negedge aclk);
            h += clks[s];
            if (ticks[s]) break;
        end
        if (n == 600) tmo;
        chk(n, e);
        chk(h, hi);
    endtask
    task automatic rel(input int m);
        int n;
        for (n = 0; n < 2500; n++) begin
            @(negedge aclk);
            if (ext_reset_n) break;
        end
        if (n == 2500) tmo;
        for (n = 1; n < 2000; n++) begin
            @(negedge aclk);
            if (core_reset_n === 1'b1) break;
        end
        if (n == 2000) tmo;
        chk(32'(n >= REF_HOLD * 2 * m && n <= (REF_HOLD + 1) * 2 * m + 16), 32'h1);
        chk(clock_multiplier, m);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(negedge aclk);
        chk(clock_multiplier, 7'h20);
        chk(core_post_divider, 5'h02);
        chk(core_reset_n, 1'b0);
        rel(32);
        rd(12'h000);
        chk({r, d}, {PCRR_RESP_OKAY, 32'h2020});
        wr(12'h000, 32'h3508);
        rd(12'h000);
        chk(d, 32'h3508);
        chk({clock_multiplier, core_post_divider, input_halving_enable}, {7'h08, 5'h04, 1'b1});
        period(0, 32, 0);
        period(1, 4, 2);
        period(2, 8, 4);
        period(3, 12, 4);
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, 32'h2008 | (i << 8));
            chk(core_post_divider, 5'h02 << i);
            period(1, 2 << i, 1 << i);
            period(0, 16, 0);
        end
        rd(12'h008);
        chk({r, d}, {PCRR_RESP_SLVERR, 32'h0});
        wr(12'h008, 32'h0000_0010);
        chk(r, PCRR_RESP_SLVERR);
        wr(12'h004, 32'hffff_ffff);
        chk(r, PCRR_RESP_OKAY);
        rd(12'h000);
        chk({r, d}, {PCRR_RESP_OKAY, 32'h2308});
        for (int c = 0; c < 4; c++) begin
            @(posedge aclk);
            code <= 2'(c);
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            repeat (20) @(negedge aclk);
            chk({clock_multiplier, core_post_divider}, {7'(mt[c]), 5'h02});
            chk({core_reset_n, input_halving_enable}, 2'h0);
            rel(mt[c]);
        end
        conclude;
    end
endmodule
